// *** shared/gil_pkg.sv ***
// Constants, types and decode helpers for the line event, lock and protect block.
// Assumes a single clock domain and a simple write port of 32-bit words.
package gil_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int LINES  = 32;
  localparam int AW     = 8;
  localparam int KEY_W  = 24;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [AW-1:0] OFS_CTRL_SET   = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL_CLR   = 8'h04;
  localparam logic [AW-1:0] OFS_OE_SET     = 8'h10;
  localparam logic [AW-1:0] OFS_OE_CLR     = 8'h14;
  localparam logic [AW-1:0] OFS_FILT_SET   = 8'h20;
  localparam logic [AW-1:0] OFS_FILT_CLR   = 8'h24;
  localparam logic [AW-1:0] OFS_IRQ_SET    = 8'h40;
  localparam logic [AW-1:0] OFS_IRQ_CLR    = 8'h44;
  localparam logic [AW-1:0] OFS_MD_SET     = 8'h50;
  localparam logic [AW-1:0] OFS_MD_CLR     = 8'h54;
  localparam logic [AW-1:0] OFS_PU_CLR     = 8'h60;
  localparam logic [AW-1:0] OFS_PU_SET     = 8'h64;
  localparam logic [AW-1:0] OFS_AB_SEL     = 8'h70;
  localparam logic [AW-1:0] OFS_DW_SET     = 8'ha0;
  localparam logic [AW-1:0] OFS_DW_CLR     = 8'ha4;
  localparam logic [AW-1:0] OFS_AIM_SET    = 8'hb0;
  localparam logic [AW-1:0] OFS_AIM_CLR    = 8'hb4;
  localparam logic [AW-1:0] OFS_EDGE_SEL   = 8'hc0;
  localparam logic [AW-1:0] OFS_LEVEL_SEL  = 8'hc4;
  localparam logic [AW-1:0] OFS_FALL_SEL   = 8'hd0;
  localparam logic [AW-1:0] OFS_RISE_SEL   = 8'hd4;
  localparam logic [AW-1:0] OFS_PROT_MODE  = 8'he4;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int                PROT_ON_BIT = 0;
  localparam int                KEY_LSB     = 8;
  localparam logic [KEY_W-1:0]  PROT_KEY    = 24'h5a5a5a;
  localparam logic [LINES-1:0]  RST_ZERO    = 32'h0000_0000;
  localparam logic [LINES-1:0]  RST_CTRL    = 32'hffff_ffff;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic             en;
    logic [AW-1:0]    addr;
    logic [LINES-1:0] data;
  } gil_wr_type;

  // Write strobe for one offset
  function automatic logic gil_hit(input gil_wr_type w, input logic [AW-1:0] ofs);
    gil_hit = w.en && (w.addr == ofs);
  endfunction

  // Offsets guarded by the write protect scheme
  function automatic logic gil_guarded(input logic [AW-1:0] a);
    case (a)
      OFS_CTRL_SET, OFS_CTRL_CLR, OFS_OE_SET, OFS_OE_CLR,
      OFS_FILT_SET, OFS_FILT_CLR, OFS_MD_SET, OFS_MD_CLR,
      OFS_PU_CLR, OFS_PU_SET, OFS_AB_SEL, OFS_DW_SET, OFS_DW_CLR: gil_guarded = 1'b1;
      default: gil_guarded = 1'b0;
    endcase
  endfunction

endpackage

// *** rtl/gil_setclr.sv ***
// Set/clear mask register with per-bit hold.
// Assumes set and clear strobes come from the same write word.
module gil_setclr
  import gil_pkg::*;
#(
  parameter logic [LINES-1:0] RST_VAL = RST_ZERO
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_sync_n,
  input  wire logic             set_we,
  input  wire logic             clr_we,
  input  wire logic [LINES-1:0] wdata,
  input  wire logic [LINES-1:0] hold,
  output logic      [LINES-1:0] q
);

  logic [LINES-1:0] q_ff;
  logic [LINES-1:0] nxt_q;

  // ****************************************
  // Next value
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    if (set_we) begin
      nxt_q = q_ff | (wdata & ~hold);
    end else if (clr_we) begin
      nxt_q = q_ff & ~(wdata & ~hold);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule

// *** rtl/gil_event_det.sv ***
// Per-line edge and level detector on two successive samples.
// Assumes the input is already synchronous to clk_sys.
module gil_event_det
  import gil_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_sync_n,
  input  wire logic [LINES-1:0] line_val,
  input  wire logic [LINES-1:0] extra_mode,
  input  wire logic [LINES-1:0] level_mode,
  input  wire logic [LINES-1:0] high_pol,
  output logic      [LINES-1:0] event_hit
);

  logic [LINES-1:0] prev_ff;
  logic             armed_ff;
  logic [LINES-1:0] nxt_prev;
  logic             nxt_armed;

  // ****************************************
  // Sample history
  // ****************************************
  always_comb begin
    nxt_prev  = line_val;
    nxt_armed = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prev_ff  <= RST_ZERO;
      armed_ff <= 1'b0;
    end else begin
      prev_ff  <= nxt_prev;
      armed_ff <= nxt_armed;
    end
  end

  // ****************************************
  // Per-line decision
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      logic rise;
      logic fall;
      assign rise = armed_ff && line_val[i] && !prev_ff[i];
      assign fall = armed_ff && !line_val[i] && prev_ff[i];
      assign event_hit[i] = !extra_mode[i] ? (rise | fall) :
                            level_mode[i]  ? (line_val[i] == high_pol[i]) :
                            high_pol[i]    ? rise : fall;
    end
  endgenerate

endmodule

// *** rtl/gil_top.sv ***
// Line event detection, line locking and keyed write protection for 32 lines.
// Assumes writes arrive as one-word strobes and line inputs are synchronous.
//
// Overview of operation
// - Interrupt enable writes set mask bits, disable writes clear them.
// - Changes found by comparing two successive clocked samples of each line.
// - Detection runs on every line whatever its configuration.
// - With extra mode off, either edge flags an event.
// - Extra mode enable and disable writes set and clear a readable mask.
// - Edge select clears, level select sets the edge/level status bits.
// - Fall/low select clears, rise/high select sets the polarity bits.
// - After reset every line selects edge and falling/low.
// - Events set pending bits; interrupt asserts when pending and masked on.
// - All thirty-two masked conditions OR into one interrupt output.
// - Reading pending status returns and clears all pending bits except those with an event in the read cycle.
// - Level mode keeps flagging while the level persists.
// - A peripheral lock input latches the line locked.
// - Locked lines ignore control, multidrive, pull-up and A/B writes.
// - Lock state of every line is readable at any time.
// - Locks stay until hardware reset; software cannot unlock.
// - Protected write while enabled sets violation flag and records target.
// - Protect mode write with correct key clears the violation flag.
// - Protection covers control, output, filter, multidrive, pull-up, A/B, direct write.
// - Filtered lines are detected on the filtered value.
module gil_top
  import gil_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire gil_wr_type       reg_wr,
  input  wire logic             pending_rd,
  input  wire logic [LINES-1:0] line_in,
  input  wire logic [LINES-1:0] line_filtered,
  input  wire logic [LINES-1:0] lock_req,
  output logic      [LINES-1:0] irq_pending_status,
  output logic      [LINES-1:0] irq_mask_status,
  output logic      [LINES-1:0] extra_mode_mask,
  output logic      [LINES-1:0] edge_level_status,
  output logic      [LINES-1:0] polarity_status,
  output logic      [LINES-1:0] line_lock_status,
  output logic      [LINES-1:0] ctrl_enable_status,
  output logic      [LINES-1:0] output_enable_status,
  output logic      [LINES-1:0] filter_enable_status,
  output logic      [LINES-1:0] multidrive_status,
  output logic      [LINES-1:0] pullup_status,
  output logic      [LINES-1:0] periph_ab_status,
  output logic      [LINES-1:0] direct_write_status,
  output logic                  protect_on,
  output logic                  protect_violation_flag,
  output logic      [AW-1:0]    violation_source,
  output logic                  irq_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic             rst_meta_ff;
  logic             rst_sync_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Write acceptance
  // ****************************************
  logic             prot_on_ff;
  logic             viol_ff;
  logic [AW-1:0]    viol_src_ff;
  logic             blocked;
  gil_wr_type       wr;
  logic [LINES-1:0] lock_ff;

  always_comb begin
    blocked = reg_wr.en && prot_on_ff && gil_guarded(reg_wr.addr);
    wr      = reg_wr;
    wr.en   = reg_wr.en && !blocked;
  end

  // ****************************************
  // Configuration masks
  // ****************************************
  logic [LINES-1:0] ctrl_q;
  logic [LINES-1:0] oe_q;
  logic [LINES-1:0] filt_q;
  logic [LINES-1:0] md_q;
  logic [LINES-1:0] pu_q;
  logic [LINES-1:0] dw_q;
  logic [LINES-1:0] imr_q;
  logic [LINES-1:0] aim_q;
  logic [LINES-1:0] els_q;
  logic [LINES-1:0] pol_q;

  gil_setclr #(.RST_VAL(RST_CTRL)) u_ctrl (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_CTRL_SET)),
    .clr_we     (gil_hit(wr, OFS_CTRL_CLR)),
    .wdata      (wr.data),
    .hold       (lock_ff),
    .q          (ctrl_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_oe (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_OE_SET)),
    .clr_we     (gil_hit(wr, OFS_OE_CLR)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (oe_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_filt (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_FILT_SET)),
    .clr_we     (gil_hit(wr, OFS_FILT_CLR)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (filt_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_md (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_MD_SET)),
    .clr_we     (gil_hit(wr, OFS_MD_CLR)),
    .wdata      (wr.data),
    .hold       (lock_ff),
    .q          (md_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_pu (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_PU_SET)),
    .clr_we     (gil_hit(wr, OFS_PU_CLR)),
    .wdata      (wr.data),
    .hold       (lock_ff),
    .q          (pu_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_dw (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_DW_SET)),
    .clr_we     (gil_hit(wr, OFS_DW_CLR)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (dw_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_imr (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_IRQ_SET)),
    .clr_we     (gil_hit(wr, OFS_IRQ_CLR)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (imr_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_aim (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_AIM_SET)),
    .clr_we     (gil_hit(wr, OFS_AIM_CLR)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (aim_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_els (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_LEVEL_SEL)),
    .clr_we     (gil_hit(wr, OFS_EDGE_SEL)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (els_q)
  );

  gil_setclr #(.RST_VAL(RST_ZERO)) u_pol (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .set_we     (gil_hit(wr, OFS_RISE_SEL)),
    .clr_we     (gil_hit(wr, OFS_FALL_SEL)),
    .wdata      (wr.data),
    .hold       (RST_ZERO),
    .q          (pol_q)
  );

  // ****************************************
  // Event detection
  // ****************************************
  logic [LINES-1:0] line_sel;
  logic [LINES-1:0] event_hit;

  always_comb begin
    line_sel = (line_filtered & filt_q) | (line_in & ~filt_q);
  end

  gil_event_det u_det (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_ff),
    .line_val   (line_sel),
    .extra_mode (aim_q),
    .level_mode (els_q),
    .high_pol   (pol_q),
    .event_hit  (event_hit)
  );

  // ****************************************
  // Pending, interrupt, lock and A/B select
  // ****************************************
  logic [LINES-1:0] pend_ff;
  logic [LINES-1:0] ab_ff;
  logic             irq_ff;
  logic [LINES-1:0] nxt_pend;
  logic [LINES-1:0] nxt_lock;
  logic [LINES-1:0] nxt_ab;
  logic             nxt_irq;
  logic [LINES-1:0] nxt_mask;

  always_comb begin
    nxt_pend = pend_ff;
    if (pending_rd) begin
      nxt_pend = RST_ZERO;
    end
    nxt_pend = nxt_pend | event_hit;
    nxt_mask = imr_q;
    if (gil_hit(wr, OFS_IRQ_SET)) begin
      nxt_mask = imr_q | wr.data;
    end else if (gil_hit(wr, OFS_IRQ_CLR)) begin
      nxt_mask = imr_q & ~wr.data;
    end
    nxt_irq  = |(nxt_pend & nxt_mask);
    nxt_lock = lock_ff | lock_req;
    nxt_ab   = ab_ff;
    if (gil_hit(wr, OFS_AB_SEL)) begin
      nxt_ab = (ab_ff & lock_ff) | (wr.data & ~lock_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pend_ff <= RST_ZERO;
      lock_ff <= RST_ZERO;
      ab_ff   <= RST_ZERO;
      irq_ff  <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      lock_ff <= nxt_lock;
      ab_ff   <= nxt_ab;
      irq_ff  <= nxt_irq;
    end
  end

  // ****************************************
  // Write protection
  // ****************************************
  logic             nxt_prot_on;
  logic             nxt_viol;
  logic [AW-1:0]    nxt_viol_src;
  logic             key_ok;

  always_comb begin
    nxt_prot_on  = prot_on_ff;
    nxt_viol     = viol_ff;
    nxt_viol_src = viol_src_ff;
    key_ok       = reg_wr.data[KEY_LSB +: KEY_W] == PROT_KEY;
    if (gil_hit(reg_wr, OFS_PROT_MODE) && key_ok) begin
      nxt_prot_on = reg_wr.data[PROT_ON_BIT];
      nxt_viol    = 1'b0;
    end
    if (blocked) begin
      nxt_viol     = 1'b1;
      nxt_viol_src = reg_wr.addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      prot_on_ff  <= 1'b0;
      viol_ff     <= 1'b0;
      viol_src_ff <= '0;
    end else begin
      prot_on_ff  <= nxt_prot_on;
      viol_ff     <= nxt_viol;
      viol_src_ff <= nxt_viol_src;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign irq_pending_status     = pend_ff;
  assign irq_mask_status        = imr_q;
  assign extra_mode_mask        = aim_q;
  assign edge_level_status      = els_q;
  assign polarity_status        = pol_q;
  assign line_lock_status       = lock_ff;
  assign ctrl_enable_status     = ctrl_q;
  assign output_enable_status   = oe_q;
  assign filter_enable_status   = filt_q;
  assign multidrive_status      = md_q;
  assign pullup_status          = pu_q;
  assign periph_ab_status       = ab_ff;
  assign direct_write_status    = dw_q;
  assign protect_on             = prot_on_ff;
  assign protect_violation_flag = viol_ff;
  assign violation_source       = viol_src_ff;
  assign irq_out                = irq_ff;

endmodule

// *** testbench/gil_monitor.sv ***
// Concurrent checks on the ports of gil_top.
// Assumes one clock domain; bound to gil_top below.
module gil_monitor
  import gil_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire gil_wr_type       reg_wr,
  input wire logic             pending_rd,
  input wire logic [LINES-1:0] line_in,
  input wire logic [LINES-1:0] line_filtered,
  input wire logic [LINES-1:0] lock_req,
  input wire logic [LINES-1:0] irq_pending_status,
  input wire logic [LINES-1:0] irq_mask_status,
  input wire logic [LINES-1:0] edge_level_status,
  input wire logic [LINES-1:0] line_lock_status,
  input wire logic [LINES-1:0] ctrl_enable_status,
  input wire logic [LINES-1:0] multidrive_status,
  input wire logic [LINES-1:0] pullup_status,
  input wire logic [LINES-1:0] periph_ab_status,
  input wire logic             protect_on,
  input wire logic             protect_violation_flag,
  input wire logic [AW-1:0]    violation_source,
  input wire logic             irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic guard_hit;
  logic mode_wr;
  logic key_ok;

  // ****************************************
  // Decode and checks
  // ****************************************
  always_comb begin
    guard_hit = reg_wr.en && protect_on && (reg_wr.addr inside {OFS_CTRL_SET, OFS_CTRL_CLR, OFS_OE_SET,
      OFS_OE_CLR, OFS_FILT_SET, OFS_FILT_CLR, OFS_MD_SET, OFS_MD_CLR, OFS_PU_CLR, OFS_PU_SET, OFS_AB_SEL,
      OFS_DW_SET, OFS_DW_CLR});
    mode_wr   = reg_wr.en && (reg_wr.addr == OFS_PROT_MODE);
    key_ok    = (reg_wr.data[LINES-1:KEY_LSB] == PROT_KEY);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_mask_set: assert property (
    reg_wr.en && reg_wr.addr == OFS_IRQ_SET |=> (irq_mask_status & $past(reg_wr.data)) == $past(reg_wr.data))
    else $error("mask not set by enable write");
  a_mask_clear: assert property (
    reg_wr.en && reg_wr.addr == OFS_IRQ_CLR |=> (irq_mask_status & $past(reg_wr.data)) == '0)
    else $error("mask not cleared by disable write");
  a_irq_or: assert property (
    irq_out == |(irq_pending_status & irq_mask_status))
    else $error("irq output differs from masked pending");
  a_read_clears: assert property (
    pending_rd && edge_level_status == '0 && line_in == $past(line_in)
    && line_filtered == $past(line_filtered)
    |=> irq_pending_status == '0)
    else $error("pending not cleared by read");
  a_lock_latch: assert property (
    |lock_req |=> (line_lock_status & $past(lock_req)) == $past(lock_req))
    else $error("lock request not latched");
  a_lock_sticky: assert property (
    (line_lock_status & $past(line_lock_status)) == $past(line_lock_status))
    else $error("lock released without reset");
  a_lock_holds: assert property (
    (((ctrl_enable_status ^ $past(ctrl_enable_status)) | (multidrive_status ^ $past(multidrive_status))
    | (pullup_status ^ $past(pullup_status)) | (periph_ab_status ^ $past(periph_ab_status)))
    & $past(line_lock_status)) == '0)
    else $error("locked line configuration changed");
  a_viol_flag: assert property (
    guard_hit |=> protect_violation_flag ##0 violation_source == $past(reg_wr.addr))
    else $error("violation not recorded");
  a_key_bad: assert property (
    mode_wr && !key_ok |=> $stable(protect_on) && $stable(protect_violation_flag))
    else $error("wrong key write took effect");
  a_key_good: assert property (
    mode_wr && key_ok |=> !protect_violation_flag && protect_on == $past(reg_wr.data[PROT_ON_BIT]))
    else $error("keyed write not applied");
endmodule

bind gil_top gil_monitor u_gil_monitor (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .pending_rd(pending_rd), .line_in(line_in),
  .line_filtered(line_filtered), .lock_req(lock_req), .irq_pending_status(irq_pending_status),
  .irq_mask_status(irq_mask_status), .edge_level_status(edge_level_status),
  .line_lock_status(line_lock_status), .ctrl_enable_status(ctrl_enable_status),
  .multidrive_status(multidrive_status), .pullup_status(pullup_status), .periph_ab_status(periph_ab_status),
  .protect_on(protect_on), .protect_violation_flag(protect_violation_flag),
  .violation_source(violation_source), .irq_out(irq_out)
);

// *** testbench/gil_line_model.sv ***
// Far side: external lines, filter output and peripheral lock requests.
// Assumes commands change at the falling edge; pins move a cycle later.
module gil_line_model
  import gil_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic [LINES-1:0] line_cmd,
  input  wire logic [LINES-1:0] filt_cmd,
  input  wire logic [LINES-1:0] lock_cmd,
  output logic      [LINES-1:0] line_in,
  output logic      [LINES-1:0] line_filtered,
  output logic      [LINES-1:0] lock_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3*LINES-1:0] cmd_ff = '0;

  initial {line_in, line_filtered, lock_req} = '0;
  always @(posedge clk_sys) cmd_ff <= {line_cmd, filt_cmd, lock_cmd};
  // Pins move at the falling edge only
  always @(negedge clk_sys) begin
    {line_in, line_filtered} <= cmd_ff[3*LINES-1:LINES];
    lock_req <= cmd_ff[LINES-1:0];
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for gil_top with the line model.
// Assumes package and design files are compiled first.
module testbench
  import gil_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [AW-1:0] GUARD [13] = '{OFS_CTRL_SET, OFS_CTRL_CLR, OFS_OE_SET, OFS_OE_CLR, OFS_FILT_SET,
    OFS_FILT_CLR, OFS_MD_SET, OFS_MD_CLR, OFS_PU_CLR, OFS_PU_SET, OFS_AB_SEL, OFS_DW_SET, OFS_DW_CLR};
  logic             clk_sys, rst_n, pending_rd, irq_out, protect_on, protect_violation_flag;
  gil_wr_type       reg_wr;
  logic [AW-1:0]    violation_source;
  logic [LINES-1:0] line_cmd, filt_cmd, lock_cmd, line_in, line_filtered, lock_req;
  logic [LINES-1:0] irq_pending_status, irq_mask_status, extra_mode_mask, edge_level_status, polarity_status;
  logic [LINES-1:0] line_lock_status, ctrl_enable_status, output_enable_status, filter_enable_status;
  logic [LINES-1:0] multidrive_status, pullup_status, periph_ab_status, direct_write_status;
  int               miscompares = 0;
  int               compares = 0;

  gil_top u_gil_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .pending_rd(pending_rd), .line_in(line_in),
    .line_filtered(line_filtered), .lock_req(lock_req), .irq_pending_status(irq_pending_status),
    .irq_mask_status(irq_mask_status), .extra_mode_mask(extra_mode_mask), .edge_level_status(edge_level_status),
    .polarity_status(polarity_status), .line_lock_status(line_lock_status),
    .ctrl_enable_status(ctrl_enable_status), .output_enable_status(output_enable_status),
    .filter_enable_status(filter_enable_status), .multidrive_status(multidrive_status),
    .pullup_status(pullup_status), .periph_ab_status(periph_ab_status), .direct_write_status(direct_write_status),
    .protect_on(protect_on), .protect_violation_flag(protect_violation_flag),
    .violation_source(violation_source), .irq_out(irq_out)
  );
  gil_line_model u_gil_line_model (
    .clk_sys(clk_sys), .line_cmd(line_cmd), .filt_cmd(filt_cmd), .lock_cmd(lock_cmd),
    .line_in(line_in), .line_filtered(line_filtered), .lock_req(lock_req)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [LINES-1:0] seen, input logic [LINES-1:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [LINES-1:0] d);
    reg_wr = '{en: 1'b1, addr: a, data: d};
    @(negedge clk_sys);
  endtask
  task automatic idle(input int n);
    reg_wr.en = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic rd();
    pending_rd = 1'b1;
    @(negedge clk_sys);
    pending_rd = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wait_pend(input logic [LINES-1:0] m);
    int n = 0;
    while ((irq_pending_status & m) !== m && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    chk("pending wait", irq_pending_status & m, m);
    if (n == 10) complete_run();
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("edge_level", edge_level_status, '0);
    chk("polarity", polarity_status, '0);
    chk("mask", irq_mask_status, '0);
    chk("lock", line_lock_status, '0);
    $display("reset done");
  endtask
  task automatic t_edges();
    wr(OFS_IRQ_SET, 32'hffff_ffff);
    wr(OFS_IRQ_CLR, 32'h0000_ffff);
    wr(OFS_IRQ_SET, 32'h0000_0000);
    wr(OFS_CTRL_CLR, 32'h0001_0000);
    wr(OFS_OE_SET, 32'h0001_0000);
    idle(1);
    chk("mask", irq_mask_status, 32'hffff_0000);
    line_cmd = 32'h0001_0001;
    wait_pend(32'h0001_0001);
    chk("irq", irq_out, 1'b1);
    rd();
    chk("pending", irq_pending_status, '0);
    chk("irq", irq_out, 1'b0);
    line_cmd = 32'h0001_0000;
    wait_pend(32'h0000_0001);
    chk("irq", irq_out, 1'b0);
    wr(OFS_IRQ_SET, 32'h0000_0001);
    chk("irq", irq_out, 1'b1);
    idle(1);
    rd();
    $display("edges done");
  endtask
  task automatic t_modes();
    wr(OFS_AIM_SET, 32'h0000_00ff);
    wr(OFS_LEVEL_SEL, 32'h0000_0038);
    wr(OFS_RISE_SEL, 32'h0000_00b5);
    wr(OFS_AIM_CLR, 32'h0000_0080);
    wr(OFS_EDGE_SEL, 32'h0000_0020);
    wr(OFS_FALL_SEL, 32'h0000_0004);
    idle(1);
    chk("extra", extra_mode_mask, 32'h0000_007f);
    chk("edge_level", edge_level_status, 32'h0000_0018);
    chk("polarity", polarity_status, 32'h0000_00b1);
    rd();
    line_cmd = 32'h0001_0095;
    idle(6);
    chk("rise", irq_pending_status & 32'h0000_009d, 32'h0000_0099);
    rd();
    chk("level", irq_pending_status & 32'h0000_0018, 32'h0000_0018);
    line_cmd = 32'h0001_0000;
    idle(6);
    chk("fall", irq_pending_status & 32'h0000_0085, 32'h0000_0084);
    rd();
    chk("level gone", irq_pending_status & 32'h0000_0010, '0);
    $display("modes done");
  endtask
  task automatic t_filter();
    wr(OFS_FILT_SET, 32'h0000_0200);
    idle(1);
    line_cmd = 32'h0001_0200;
    idle(6);
    chk("raw ignored", irq_pending_status & 32'h0000_0200, '0);
    filt_cmd = 32'h0000_0200;
    wait_pend(32'h0000_0200);
    $display("filter done");
  endtask
  task automatic t_lock();
    lock_cmd = 32'h0010_0000;
    @(negedge clk_sys);
    lock_cmd = '0;
    idle(3);
    chk("lock", line_lock_status, 32'h0010_0000);
    wr(OFS_CTRL_CLR, 32'h0030_0000);
    wr(OFS_MD_SET, 32'h0030_0000);
    wr(OFS_PU_SET, 32'h0030_0000);
    wr(OFS_AB_SEL, 32'h0030_0000);
    wr(OFS_OE_SET, 32'h0030_0000);
    idle(1);
    chk("ctrl", ctrl_enable_status, 32'hffde_ffff);
    chk("md", multidrive_status, 32'h0020_0000);
    chk("pu", pullup_status, 32'h0020_0000);
    chk("ab", periph_ab_status, 32'h0020_0000);
    chk("oe", output_enable_status, 32'h0031_0000);
    chk("lock", line_lock_status, 32'h0010_0000);
    $display("lock done");
  endtask
  task automatic t_protect();
    wr(OFS_PROT_MODE, {PROT_KEY, 8'h01});
    idle(1);
    chk("prot on", protect_on, 1'b1);
    foreach (GUARD[i]) begin
      wr(GUARD[i], 32'hffff_ffff);
      idle(1);
      chk("flag", protect_violation_flag, 1'b1);
      chk("source", violation_source, GUARD[i]);
    end
    chk("ctrl", ctrl_enable_status, 32'hffde_ffff);
    chk("oe", output_enable_status, 32'h0031_0000);
    chk("filt", filter_enable_status, 32'h0000_0200);
    chk("md", multidrive_status, 32'h0020_0000);
    chk("pu", pullup_status, 32'h0020_0000);
    chk("ab", periph_ab_status, 32'h0020_0000);
    chk("dw", direct_write_status, '0);
    wr(OFS_PROT_MODE, 32'h0000_0000);
    idle(1);
    chk("bad key", {protect_on, protect_violation_flag}, 2'b11);
    wr(OFS_PROT_MODE, {PROT_KEY, 8'h00});
    wr(8'h0c, 32'hffff_ffff);
    wr(OFS_DW_SET, 32'h0000_000f);
    idle(1);
    chk("good key", {protect_on, protect_violation_flag}, 2'b00);
    chk("dw", direct_write_status, 32'h0000_000f);
    do_reset();
    chk("lock", line_lock_status, '0);
    $display("protect done");
  endtask

  initial begin
    reg_wr = '0;
    pending_rd = 1'b0;
    line_cmd = '0;
    filt_cmd = '0;
    lock_cmd = '0;
    do_reset();
    t_reset();
    t_edges();
    t_modes();
    t_filter();
    t_lock();
    t_protect();
    complete_run();
  end
endmodule
